// >>> include/drc_pkg.sv
// drc_pkg: parameter indices, control word layout and reset values
package drc_pkg;
   localparam int IDX_W  = 8;
   localparam int CW_W   = 16;
   localparam int POS_W  = 32;
   localparam int GATE_W = 8;
   localparam int ERR_W  = 8;

   localparam logic [IDX_W-1:0]  IDX_CTRL_GATE = 8'h6d;
   localparam logic [IDX_W-1:0]  IDX_RUN_CTRL  = 8'h6e;
   localparam logic [IDX_W-1:0]  IDX_TGT_GATE  = 8'h6f;
   localparam logic [IDX_W-1:0]  IDX_GOAL_POS  = 8'h70;

   localparam logic [GATE_W-1:0] GATE_RESET    = 8'h00;
   localparam logic [GATE_W-1:0] GATE_SUPPRESS = 8'h00;
   localparam logic [CW_W-1:0]   CW_RESET      = 16'h0000;
   localparam logic [POS_W-1:0]  POS_RESET     = 32'h0000_0000;
   localparam logic [ERR_W-1:0]  ERR_RESET     = 8'h00;
   localparam logic [CW_W-1:0]   CW_ASSIGNED   = 16'h5dff;

   localparam int CW_MAN_UP   = 0;
   localparam int CW_MAN_DN   = 1;
   localparam int CW_XFER     = 2;
   localparam int CW_JOG_CONT = 3;
   localparam int CW_RELEASE  = 4;
   localparam int CW_KEY_EN   = 5;
   localparam int CW_NO_LOOP  = 6;
   localparam int CW_REF_LOOP = 7;
   localparam int CW_JOG_UP   = 8;
   localparam int CW_READJ    = 10;
   localparam int CW_BRAKE    = 11;
   localparam int CW_DRAG     = 12;
   localparam int CW_ERR_CLR  = 14;
endpackage : drc_pkg

// >>> rtl/drc_sync.sv
// drc_sync: two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module drc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_reset,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta;

   // meta feeds only the second stage
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         meta   <= '0;
         o_sync <= '0;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule : drc_sync

// >>> rtl/drc_write_gate.sv
// drc_write_gate: one-shot gate parameter that can suppress the next write
`timescale 1ns/1ps
module drc_write_gate
   import drc_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_reset,
   input  wire logic              i_wr,
   input  wire logic              i_sel_gate,
   input  wire logic              i_sel_target,
   input  wire logic [GATE_W-1:0] i_wdata,
   output logic      [GATE_W-1:0] o_value,
   output logic                   o_block
);
   logic armed;
   logic next_armed;
   logic [GATE_W-1:0] next_value;

   // any write consumes the arming, so only the very next write is hit
   always_comb begin
      next_armed = armed;
      next_value = o_value;
      if (i_wr) begin
         next_armed = i_sel_gate && (i_wdata == GATE_SUPPRESS);
         if (i_sel_gate) begin
            next_value = i_wdata;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         armed   <= 1'b0;
         o_value <= GATE_RESET;
      end else begin
         armed   <= next_armed;
         o_value <= next_value;
      end
   end

   assign o_block = armed && i_wr && i_sel_target;
endmodule : drc_write_gate

// >>> rtl/drc_run_command.sv
// drc_run_command: run command parameters and control word decode
`timescale 1ns/1ps
module drc_run_command (
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_reset,
   input  wire logic                      i_par_wr,
   input  wire logic                      i_par_rd,
   input  wire logic [drc_pkg::IDX_W-1:0] i_par_index,
   input  wire logic [drc_pkg::POS_W-1:0] i_par_wdata,
   input  wire logic                      i_pd_valid,
   input  wire logic [drc_pkg::POS_W-1:0] i_pd_target,
   input  wire logic                      i_link_up,
   input  wire logic                      i_key_up,
   input  wire logic                      i_key_down,
   input  wire logic [drc_pkg::ERR_W-1:0] i_err_set,
   output logic      [drc_pkg::POS_W-1:0] o_par_rdata,
   output logic                           o_par_ack,
   output logic                           o_par_err,
   output logic                           o_axis_drive,
   output logic                           o_manual_up,
   output logic                           o_manual_down,
   output logic                           o_jog_up,
   output logic                           o_jog_step,
   output logic                           o_key_up,
   output logic                           o_key_down,
   output logic                           o_no_loop,
   output logic                           o_ref_loop,
   output logic                           o_readjust,
   output logic                           o_brake_free_run,
   output logic                           o_drag_corr,
   output logic                           o_pos_start,
   output logic      [drc_pkg::POS_W-1:0] o_goal_position,
   output logic      [drc_pkg::CW_W-1:0]  o_run_control,
   output logic      [drc_pkg::ERR_W-1:0] o_err_status
);
   import drc_pkg::*;

   logic              sel_cgate;
   logic              sel_cw;
   logic              sel_tgate;
   logic              sel_goal;
   logic              hit;
   logic              cw_block;
   logic              goal_block;
   logic              cw_ok;
   logic              goal_ok;
   logic              pd_take;
   logic              key_en;
   logic [GATE_W-1:0] ctrl_gate;
   logic [GATE_W-1:0] tgt_gate;
   logic [1:0]        keys;
   logic [CW_W-1:0]   cw_eff;
   logic [CW_W-1:0]   cw_prev;
   logic [CW_W-1:0]   cw_rise;
   logic              rel;

   logic [POS_W-1:0]  next_par_rdata;
   logic              next_par_ack;
   logic              next_par_err;
   logic [CW_W-1:0]   next_run_control;
   logic [POS_W-1:0]  next_goal_position;
   logic [CW_W-1:0]   next_cw_prev;
   logic              next_axis_drive;
   logic              next_manual_up;
   logic              next_manual_down;
   logic              next_jog_up;
   logic              next_jog_step;
   logic              next_key_up;
   logic              next_key_down;
   logic              next_no_loop;
   logic              next_ref_loop;
   logic              next_readjust;
   logic              next_brake_free_run;
   logic              next_drag_corr;
   logic              next_pos_start;
   logic [ERR_W-1:0]  next_err_status;

   // address decode of the indexed parameters
   assign sel_cgate = (i_par_index == IDX_CTRL_GATE);
   assign sel_cw    = (i_par_index == IDX_RUN_CTRL);
   assign sel_tgate = (i_par_index == IDX_TGT_GATE);
   assign sel_goal  = (i_par_index == IDX_GOAL_POS);
   assign hit       = sel_cgate || sel_cw || sel_tgate || sel_goal;

   drc_write_gate u_ctrl_gate (
      .i_sys_clk    (i_sys_clk),
      .i_reset      (i_reset),
      .i_wr         (i_par_wr),
      .i_sel_gate   (sel_cgate),
      .i_sel_target (sel_cw),
      .i_wdata      (i_par_wdata[GATE_W-1:0]),
      .o_value      (ctrl_gate),
      .o_block      (cw_block)
   );

   drc_write_gate u_tgt_gate (
      .i_sys_clk    (i_sys_clk),
      .i_reset      (i_reset),
      .i_wr         (i_par_wr),
      .i_sel_gate   (sel_tgate),
      .i_sel_target (sel_goal),
      .i_wdata      (i_par_wdata[GATE_W-1:0]),
      .o_value      (tgt_gate),
      .o_block      (goal_block)
   );

   // the jog keys are raw pins
   drc_sync #(
      .WIDTH (2)
   ) u_key_sync (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_async   ({i_key_up, i_key_down}),
      .o_sync    (keys)
   );

   assign cw_ok   = i_par_wr && sel_cw && !cw_block;
   assign goal_ok = i_par_wr && sel_goal && !goal_block;
   // stray bits are kept for readback but never reach motion
   assign cw_eff  = o_run_control & CW_ASSIGNED;
   assign cw_rise = cw_eff & ~cw_prev;
   assign rel     = cw_eff[CW_RELEASE];
   assign pd_take = i_pd_valid && cw_eff[CW_XFER];
   assign key_en  = !i_link_up || cw_eff[CW_KEY_EN];

   always_comb begin
      next_run_control   = o_run_control;
      next_goal_position = o_goal_position;
      if (cw_ok) begin
         next_run_control = i_par_wdata[CW_W-1:0];
      end
      if (pd_take) begin
         next_goal_position = i_pd_target;
      end
      // a parameter write wins over process data in the same cycle
      if (goal_ok) begin
         next_goal_position = i_par_wdata;
      end
   end

   always_comb begin
      next_par_ack   = i_par_wr || i_par_rd;
      next_par_err   = (i_par_wr || i_par_rd) && !hit;
      next_par_rdata = '0;
      if (i_par_rd && !i_par_wr) begin
         case (i_par_index)
            IDX_CTRL_GATE: next_par_rdata = POS_W'(ctrl_gate);
            IDX_RUN_CTRL:  next_par_rdata = POS_W'(o_run_control);
            IDX_TGT_GATE:  next_par_rdata = POS_W'(tgt_gate);
            IDX_GOAL_POS:  next_par_rdata = o_goal_position;
            default:       next_par_rdata = '0;
         endcase
      end
   end

   always_comb begin
      next_cw_prev        = cw_eff;
      next_axis_drive     = rel;
      next_manual_up      = rel && cw_eff[CW_MAN_UP] && !cw_eff[CW_MAN_DN];
      next_manual_down    = rel && cw_eff[CW_MAN_DN] && !cw_eff[CW_MAN_UP];
      // jog moves without the axis release
      next_jog_up         = cw_eff[CW_JOG_UP] && cw_eff[CW_JOG_CONT];
      next_jog_step       = cw_rise[CW_JOG_UP] && !cw_eff[CW_JOG_CONT];
      next_key_up         = keys[1] && key_en;
      next_key_down       = keys[0] && key_en;
      next_no_loop        = cw_eff[CW_NO_LOOP];
      next_ref_loop       = rel && cw_eff[CW_REF_LOOP];
      next_readjust       = rel && cw_rise[CW_READJ];
      next_brake_free_run = rel && cw_eff[CW_BRAKE];
      next_drag_corr      = cw_eff[CW_DRAG];
      next_pos_start      = rel && (pd_take || goal_ok);
      // new errors win over the clear edge
      next_err_status     = (o_err_status & ~{ERR_W{cw_rise[CW_ERR_CLR]}})
                            | i_err_set;
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_par_rdata      <= POS_RESET;
         o_par_ack        <= 1'b0;
         o_par_err        <= 1'b0;
         o_run_control    <= CW_RESET;
         o_goal_position  <= POS_RESET;
         cw_prev          <= CW_RESET;
         o_axis_drive     <= 1'b0;
         o_manual_up      <= 1'b0;
         o_manual_down    <= 1'b0;
         o_jog_up         <= 1'b0;
         o_jog_step       <= 1'b0;
         o_key_up         <= 1'b0;
         o_key_down       <= 1'b0;
         o_no_loop        <= 1'b0;
         o_ref_loop       <= 1'b0;
         o_readjust       <= 1'b0;
         o_brake_free_run <= 1'b0;
         o_drag_corr      <= 1'b0;
         o_pos_start      <= 1'b0;
         o_err_status     <= ERR_RESET;
      end else begin
         o_par_rdata      <= next_par_rdata;
         o_par_ack        <= next_par_ack;
         o_par_err        <= next_par_err;
         o_run_control    <= next_run_control;
         o_goal_position  <= next_goal_position;
         cw_prev          <= next_cw_prev;
         o_axis_drive     <= next_axis_drive;
         o_manual_up      <= next_manual_up;
         o_manual_down    <= next_manual_down;
         o_jog_up         <= next_jog_up;
         o_jog_step       <= next_jog_step;
         o_key_up         <= next_key_up;
         o_key_down       <= next_key_down;
         o_no_loop        <= next_no_loop;
         o_ref_loop       <= next_ref_loop;
         o_readjust       <= next_readjust;
         o_brake_free_run <= next_brake_free_run;
         o_drag_corr      <= next_drag_corr;
         o_pos_start      <= next_pos_start;
         o_err_status     <= next_err_status;
      end
   end

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);

   sequence s_gate_zero_cw;
      i_par_wr && sel_cgate && (i_par_wdata[GATE_W-1:0] == GATE_SUPPRESS) ##1 !i_par_wr;
   endsequence

   sequence s_gate_zero_goal;
      i_par_wr && sel_tgate && (i_par_wdata[GATE_W-1:0] == GATE_SUPPRESS) ##1 !i_par_wr;
   endsequence

   sequence s_jog_rise;
      cw_eff[CW_JOG_UP] && !cw_prev[CW_JOG_UP] && !cw_eff[CW_JOG_CONT];
   endsequence

   sequence s_step_pulse;
      o_jog_step ##1 !o_jog_step;
   endsequence

   property p_cw_suppress;
      s_gate_zero_cw ##1 (i_par_wr && sel_cw) |=> $stable(o_run_control);
   endproperty
   a_cw_suppress: assert property (p_cw_suppress)
      else $error("control word changed by a suppressed write");

   property p_goal_suppress;
      s_gate_zero_goal ##1 (i_par_wr && sel_goal && !pd_take)
         |=> $stable(o_goal_position) && !o_pos_start;
   endproperty
   a_goal_suppress: assert property (p_goal_suppress)
      else $error("target changed by a suppressed write");

   property p_manual_dir;
      ##1 (o_manual_up == $past(rel && cw_eff[CW_MAN_UP] && !cw_eff[CW_MAN_DN]))
          && !(o_manual_up && o_manual_down);
   endproperty
   a_manual_dir: assert property (p_manual_dir)
      else $error("manual run output does not follow control word");

   property p_pd_needs_xfer;
      (i_pd_valid && !cw_eff[CW_XFER] && !goal_ok)
         |=> !o_pos_start && $stable(o_goal_position);
   endproperty
   a_pd_needs_xfer: assert property (p_pd_needs_xfer)
      else $error("process data target taken without transfer bit");

   property p_jog_step;
      s_jog_rise |=> s_step_pulse;
   endproperty
   a_jog_step: assert property (p_jog_step)
      else $error("single jog step not a one cycle pulse");

   property p_release;
      (o_manual_up || o_manual_down || o_pos_start || o_ref_loop || o_brake_free_run)
         |-> $past(rel);
   endproperty
   a_release: assert property (p_release)
      else $error("axis moved without release");

   property p_keys_gated;
      (i_link_up && !cw_eff[CW_KEY_EN]) |=> !o_key_up && !o_key_down;
   endproperty
   a_keys_gated: assert property (p_keys_gated)
      else $error("external key active over link without key enable");

   property p_readjust_pulse;
      o_readjust |=> !o_readjust;
   endproperty
   a_readjust_pulse: assert property (p_readjust_pulse)
      else $error("readjust trigger longer than one cycle");

   property p_err_clear;
      (cw_rise[CW_ERR_CLR] && (i_err_set == ERR_RESET)) |=> (o_err_status == ERR_RESET);
   endproperty
   a_err_clear: assert property (p_err_clear)
      else $error("error bits not cleared");

   property p_goal_store;
      goal_ok |=> (o_goal_position == $past(i_par_wdata));
   endproperty
   a_goal_store: assert property (p_goal_store)
      else $error("accepted target not stored");

   property p_stray_bits;
      (cw_eff == $past(cw_eff)) && (o_run_control != $past(o_run_control))
         |=> $stable(o_axis_drive) && $stable(o_jog_up) && $stable(o_no_loop);
   endproperty
   a_stray_bits: assert property (p_stray_bits)
      else $error("unassigned control bit changed motion");
endmodule : drc_run_command

// >>> dv/drc_master_model.sv
// drc_master_model: link master side issuing parameter accesses and targets
`timescale 1ns/1ps
module drc_master_model
   import drc_pkg::*;
(
   input  wire logic             i_sys_clk,
   input  wire logic             i_par_ack,
   input  wire logic             i_par_err,
   input  wire logic [POS_W-1:0] i_par_rdata,
   output logic                  o_par_wr,
   output logic                  o_par_rd,
   output logic      [IDX_W-1:0] o_par_index,
   output logic      [POS_W-1:0] o_par_wdata,
   output logic                  o_pd_valid,
   output logic      [POS_W-1:0] o_pd_target
);
   initial begin
      o_par_wr    = 1'b0;
      o_par_rd    = 1'b0;
      o_par_index = 8'h00;
      o_par_wdata = 32'h0000_0000;
      o_pd_valid  = 1'b0;
      o_pd_target = 32'h0000_0000;
   end

   // one strobe per request; the answer is awaited for a bounded number of cycles
   task automatic access(input logic wr, input logic [IDX_W-1:0] idx,
                         input logic [POS_W-1:0] data, output logic [POS_W-1:0] rdata,
                         output logic err, output logic ok);
      ok    = 1'b0;
      err   = 1'b0;
      rdata = 32'h0000_0000;
      @(negedge i_sys_clk);
      o_par_wr    = wr;
      o_par_rd    = !wr;
      o_par_index = idx;
      o_par_wdata = data;
      // strobe is a one cycle pulse; holding it would issue a second request
      @(negedge i_sys_clk);
      o_par_wr    = 1'b0;
      o_par_rd    = 1'b0;
      // ack stands for one cycle only, so look before the next edge passes
      for (int i = 0; i < 4 && !ok; i++) begin
         if (i_par_ack === 1'b1) begin
            ok    = 1'b1;
            rdata = i_par_rdata;
            err   = i_par_err;
         end else begin
            @(negedge i_sys_clk);
         end
      end
      // released lines flip so a late sample cannot match by luck
      o_par_index = ~idx;
      o_par_wdata = ~data;
   endtask : access

   // raw lets a scenario break the zero-fill of unused bits on purpose
   task automatic write(input logic [IDX_W-1:0] idx, input logic [POS_W-1:0] data,
                        input logic raw, output logic err, output logic ok);
      logic [POS_W-1:0] d;
      logic [POS_W-1:0] rd;
      d = data;
      if (idx == IDX_RUN_CTRL && !raw) d = data & {16'h0000, CW_ASSIGNED};
      access(1'b1, idx, d, rd, err, ok);
   endtask : write

   task automatic send_target(input logic [POS_W-1:0] t);
      @(negedge i_sys_clk);
      o_pd_valid  = 1'b1;
      o_pd_target = t;
      @(negedge i_sys_clk);
      o_pd_valid  = 1'b0;
      o_pd_target = ~t;
   endtask : send_target
endmodule : drc_master_model

// >>> dv/drc_run_command_bench.sv
// drc_run_command_bench: self-checking bench for the run command parameters
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin n_tests++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %s expected %h seen %h", what, exp, got); end end
module drc_run_command_bench;
   import drc_pkg::*;
   logic             clk, reset, link_up, key_up, key_down;
   logic [ERR_W-1:0] err_set;
   logic             par_wr, par_rd, pd_valid, par_ack, par_err;
   logic [IDX_W-1:0] par_index;
   logic [POS_W-1:0] par_wdata, pd_target, par_rdata, goal;
   logic             axis, m_up, m_dn, j_up, j_step, k_up, k_dn, no_loop, ref_loop;
   logic             readj, brake, drag, pos_start;
   logic [CW_W-1:0]  run_ctrl;
   logic [ERR_W-1:0] err_status;
   logic [9:0]       motion;
   int               fails = 0;
   int               n_tests = 0;

   assign motion = {m_up, m_dn, j_up, j_step, no_loop, ref_loop, readj, brake, drag, axis};

   drc_master_model mm (.i_sys_clk(clk), .i_par_ack(par_ack), .i_par_err(par_err),
      .i_par_rdata(par_rdata), .o_par_wr(par_wr), .o_par_rd(par_rd),
      .o_par_index(par_index), .o_par_wdata(par_wdata), .o_pd_valid(pd_valid),
      .o_pd_target(pd_target));

   drc_run_command dut (.i_sys_clk(clk), .i_reset(reset), .i_par_wr(par_wr),
      .i_par_rd(par_rd), .i_par_index(par_index), .i_par_wdata(par_wdata),
      .i_pd_valid(pd_valid), .i_pd_target(pd_target), .i_link_up(link_up),
      .i_key_up(key_up), .i_key_down(key_down), .i_err_set(err_set),
      .o_par_rdata(par_rdata), .o_par_ack(par_ack), .o_par_err(par_err),
      .o_axis_drive(axis), .o_manual_up(m_up), .o_manual_down(m_dn), .o_jog_up(j_up),
      .o_jog_step(j_step), .o_key_up(k_up), .o_key_down(k_dn), .o_no_loop(no_loop),
      .o_ref_loop(ref_loop), .o_readjust(readj), .o_brake_free_run(brake),
      .o_drag_corr(drag), .o_pos_start(pos_start), .o_goal_position(goal),
      .o_run_control(run_ctrl), .o_err_status(err_status));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [POS_W-1:0] d,
                     input logic raw = 1'b0);
      logic e, ok;
      mm.write(idx, d, raw, e, ok);
      if (ok !== 1'b1) begin
         fails++;
         stop_test();
      end
   endtask : wr

   task automatic rd(input logic [IDX_W-1:0] idx, output logic [POS_W-1:0] v,
                     output logic e);
      logic ok;
      mm.access(1'b0, idx, 32'h0000_0000, v, e, ok);
      if (ok !== 1'b1) begin
         fails++;
         stop_test();
      end
   endtask : rd

   task automatic t_reset();
      logic [IDX_W-1:0] idxs[4] = '{IDX_CTRL_GATE, IDX_RUN_CTRL, IDX_TGT_GATE, IDX_GOAL_POS};
      logic [POS_W-1:0] v;
      logic             e;
      `CHK("motion after reset", 10'h000, motion)
      foreach (idxs[i]) begin
         rd(idxs[i], v, e);
         `CHK("register reset value", 32'h0000_0000, v)
      end
      rd(8'h71, v, e);
      `CHK("unmapped index error", 1'b1, e)
   endtask : t_reset

   task automatic t_gate_cw();
      logic [POS_W-1:0] v;
      logic             e;
      wr(IDX_CTRL_GATE, 32'h0000_0000);
      wr(IDX_RUN_CTRL, 32'h0000_0010);
      rd(IDX_RUN_CTRL, v, e);
      `CHK("suppressed control word", 32'h0000_0000, v)
      wr(IDX_RUN_CTRL, 32'h0000_0010);
      rd(IDX_RUN_CTRL, v, e);
      `CHK("control word after gate", 32'h0000_0010, v)
      // a nonzero gate value must not arm suppression
      wr(IDX_CTRL_GATE, 32'h0000_0001);
      wr(IDX_RUN_CTRL, 32'h0000_0000);
      `CHK("control word with gate 1", 16'h0000, run_ctrl)
      wr(IDX_CTRL_GATE, 32'h0000_0000);
      wr(IDX_TGT_GATE, 32'h0000_0001);
      wr(IDX_RUN_CTRL, 32'h0000_0010);
      `CHK("gate spent by other write", 16'h0010, run_ctrl)
   endtask : t_gate_cw

   task automatic t_gate_tgt();
      logic [POS_W-1:0] v;
      logic             e;
      wr(IDX_TGT_GATE, 32'h0000_0000);
      wr(IDX_GOAL_POS, 32'h0000_1388);
      `CHK("suppressed target", 32'h0000_0000, goal)
      wr(IDX_GOAL_POS, 32'hffff_ff9c);
      rd(IDX_GOAL_POS, v, e);
      `CHK("negative target readback", 32'hffff_ff9c, v)
   endtask : t_gate_tgt

   task automatic t_bits();
      logic [CW_W-1:0] cws[11] = '{16'h0011, 16'h0013, 16'h0012, 16'h0002, 16'h0100,
                                   16'h0108, 16'h14d0, 16'h0880, 16'h0810, 16'h0010,
                                   16'ha210};
      logic [9:0]      exps[11] = '{10'h201, 10'h001, 10'h101, 10'h000, 10'h040,
                                    10'h080, 10'h03b, 10'h000, 10'h005, 10'h001,
                                    10'h001};
      // last word differs from the one before only in unassigned bits
      for (int i = 0; i < 11; i++) begin
         wr(IDX_RUN_CTRL, {16'h0000, cws[i]}, i == 10);
         @(negedge clk);
         `CHK("decoded run outputs", exps[i], motion)
      end
      `CHK("stored word with unused bits", 16'ha210, run_ctrl)
   endtask : t_bits

   task automatic t_keys();
      wr(IDX_RUN_CTRL, 32'h0000_0000);
      link_up = 1'b1;
      key_up  = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("key ignored while linked", 1'b0, k_up)
      wr(IDX_RUN_CTRL, 32'h0000_0020);
      @(negedge clk);
      `CHK("key enabled by bit 5", 1'b1, k_up)
      key_up   = 1'b0;
      key_down = 1'b1;
      link_up  = 1'b0;
      wr(IDX_RUN_CTRL, 32'h0000_0000);
      repeat (3) @(negedge clk);
      `CHK("key active without link", 1'b1, k_dn)
      key_down = 1'b0;
   endtask : t_keys

   task automatic t_pd();
      wr(IDX_RUN_CTRL, 32'h0000_0010);
      @(negedge clk);
      mm.send_target(32'h0000_0fa0);
      `CHK("target without transfer bit", 32'hffff_ff9c, goal)
      `CHK("no start without transfer bit", 1'b0, pos_start)
      wr(IDX_RUN_CTRL, 32'h0000_0014);
      @(negedge clk);
      mm.send_target(32'h0000_0fa0);
      `CHK("target with transfer bit", 32'h0000_0fa0, goal)
      `CHK("start with transfer bit", 1'b1, pos_start)
   endtask : t_pd

   task automatic t_err();
      err_set = 8'h05;
      @(negedge clk);
      err_set = 8'h00;
      @(negedge clk);
      `CHK("error bits held", 8'h05, err_status)
      wr(IDX_RUN_CTRL, 32'h0000_4000);
      repeat (2) @(negedge clk);
      `CHK("error bits cleared", 8'h00, err_status)
      // holding bit 14 must not wipe errors raised later
      err_set = 8'h80;
      @(negedge clk);
      err_set = 8'h00;
      repeat (2) @(negedge clk);
      `CHK("new error kept", 8'h80, err_status)
   endtask : t_err

   initial begin
      reset    = 1'b1;
      link_up  = 1'b0;
      key_up   = 1'b0;
      key_down = 1'b0;
      err_set  = 8'h00;
      repeat (8) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      t_reset();
      $display("reset values done");
      t_gate_cw();
      $display("control word gate done");
      t_gate_tgt();
      $display("target gate done");
      t_bits();
      $display("control bits done");
      t_keys();
      $display("external keys done");
      t_pd();
      $display("process data done");
      t_err();
      $display("error clear done");
      stop_test();
   end
endmodule : drc_run_command_bench
